// ### src/rstack_pkg.sv
// package: constants, types and register map of the return stack and reset-cause block
// assumes: core clock 50 MHz, one clock domain
package rstack_pkg;
   localparam int PC_W = 21;
   localparam int PTR_W = 5;
   localparam int DEPTH = 31;
   localparam logic [PTR_W-1:0] PTR_LAST = 5'h1f;
   localparam logic [PTR_W-1:0] PTR_ZERO = 5'h00;
   localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
   localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
   // register addresses on the plain register port
   localparam logic [2:0] ADDR_RETURN_STACK_POINTER = 3'h0;
   localparam logic [2:0] ADDR_TOP_LOW = 3'h1;
   localparam logic [2:0] ADDR_TOP_HIGH = 3'h2;
   localparam logic [2:0] ADDR_TOP_UPPER = 3'h3;
   localparam logic [2:0] ADDR_RESET_CONTROL_STATUS = 3'h4;
   // stack pointer register fields
   localparam int SP_FULL_BIT = 7;
   localparam int SP_UNF_BIT = 6;
   // reset control/status fields
   localparam int RC_INTERRUPT_PRIORITY_ENABLE_BIT = 7;
   localparam int RC_SBOR_BIT = 6;
   localparam int RC_RI_BIT = 4;
   localparam int RC_TO_BIT = 3;
   localparam int RC_PD_BIT = 2;
   localparam int RC_POR_BIT = 1;
   localparam int RC_BOR_BIT = 0;
   localparam logic [1:0] BOR_SOFT_MODE = 2'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] work;
      logic [7:0] bank;
   } core_ctx_t;

   typedef struct packed {
      logic push;
      logic pop;
      logic call_fast;
      logic ret_fast;
      logic irq_vector;
      logic return_from_interrupt_fast;
   } stack_op_t;

   // reset / wake-up event codes
   typedef enum logic [3:0] {
      EV_NONE = 4'h0,
      EV_POR = 4'h1,
      EV_RESET_INSTR = 4'h2,
      EV_BROWNOUT = 4'h3,
      EV_EXTERNAL_MASTER_CLEAR_RUN = 4'h4,
      EV_EXTERNAL_MASTER_CLEAR_SLEEP = 4'h5,
      EV_WDT_RUN = 4'h6,
      EV_EXTERNAL_MASTER_CLEAR_FULL = 4'h7,
      EV_WDT_WAKE = 4'h8,
      EV_IRQ_WAKE = 4'h9
   } reset_event_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_FAULT = 2'b01,
      ST_HOLD = 2'b11
   } fault_state_t;
endpackage

// ### src/stack_ram.sv
// return address storage: 31 entries, one write port, one async read port
// assumes: index 0 is never written, entries 1..31 hold data
`timescale 1ns/100ps
module stack_ram (
   input wire logic i_mclk,
   input wire logic i_we,
   input wire logic [rstack_pkg::PTR_W-1:0] i_waddr,
   input wire logic [rstack_pkg::PC_W-1:0] i_wdata,
   input wire logic [rstack_pkg::PTR_W-1:0] i_raddr,
   output logic [rstack_pkg::PC_W-1:0] o_rdata
);
   logic [rstack_pkg::PC_W-1:0] mem [1:rstack_pkg::DEPTH];

   // contents are not reset: unknown after power-on, kept through other resets
   always_ff @(posedge i_mclk) begin
      if (i_we && i_waddr != rstack_pkg::PTR_ZERO) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_comb begin
      if (i_raddr == rstack_pkg::PTR_ZERO) begin
         o_rdata = rstack_pkg::PC_RESET;
      end else begin
         o_rdata = mem[i_raddr];
      end
   end
endmodule

// ### src/return_stack_reset_flags.sv
// return address stack, fast context shadow and reset-cause flags of an 8-bit core
// assumes: core sequencer drives one-cycle op strobes and reset events, registers on a plain port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

module return_stack_reset_flags (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire rstack_pkg::stack_op_t i_op,
   input wire logic [rstack_pkg::PC_W-1:0] i_pc,
   input wire rstack_pkg::core_ctx_t i_ctx,
   input wire rstack_pkg::reset_event_t i_event,
   input wire logic i_stack_fault_reset_enable,
   input wire logic [1:0] i_brownout_mode_config,
   input wire logic i_high_irq_global_enable,
   input wire logic i_low_irq_global_enable,
   input wire logic i_irq_high_pending,
   output logic [rstack_pkg::PC_W-1:0] o_top_of_stack,
   output logic [rstack_pkg::PC_W-1:0] o_pc_load,
   output logic o_pc_load_valid,
   output rstack_pkg::core_ctx_t o_ctx_restore,
   output logic o_ctx_restore_valid,
   output logic o_device_reset
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [rstack_pkg::PTR_W-1:0] ptr_reg;
   logic full_reg;
   logic unf_reg;
   rstack_pkg::core_ctx_t shadow_reg;
   logic interrupt_priority_enable_reg;
   logic software_brownout_enable_reg;
   logic ri_reg;
   logic to_reg;
   logic pd_reg;
   logic por_reg;
   logic bor_reg;
   rstack_pkg::fault_state_t fault_reg;
   rstack_pkg::fault_state_t fault_next;
   logic [rstack_pkg::PC_W-1:0] top_rd;
   logic [rstack_pkg::PC_W-1:0] top_wdata;
   logic top_we;
   logic [rstack_pkg::PTR_W-1:0] top_waddr;
   logic do_push;
   logic do_pop;
   logic push_full;
   logic pop_empty;
   logic fault_hit;
   logic is_por;
   logic is_reset;
   logic wr_sp;

   function automatic logic [rstack_pkg::PC_W-1:0] put_byte(input logic [rstack_pkg::PC_W-1:0] val,
                                                           input logic [1:0] lane,
                                                           input logic [7:0] b);
      logic [23:0] wide;
      wide = {3'h0, val};
      wide[lane*8 +: 8] = b;
      return wide[rstack_pkg::PC_W-1:0];
   endfunction

   function automatic logic [7:0] get_byte(input logic [rstack_pkg::PC_W-1:0] val, input logic [1:0] lane);
      logic [23:0] wide;
      wide = {3'h0, val};
      return wide[lane*8 +: 8];
   endfunction

   assign is_por = (i_event == rstack_pkg::EV_POR);
   assign is_reset = (i_event != rstack_pkg::EV_NONE) && (i_event != rstack_pkg::EV_WDT_WAKE)
      && (i_event != rstack_pkg::EV_IRQ_WAKE);
   assign do_push = (i_op.push || i_op.call_fast || i_op.irq_vector) && !is_reset;
   assign do_pop = (i_op.pop || i_op.ret_fast || i_op.return_from_interrupt_fast) && !is_reset && !do_push;
   assign push_full = do_push && (ptr_reg == rstack_pkg::PTR_LAST);
   assign pop_empty = do_pop && (ptr_reg == rstack_pkg::PTR_ZERO);
   assign wr_sp = i_wr && (i_addr == rstack_pkg::ADDR_RETURN_STACK_POINTER);

   // ----------------------------------------------------------------
   // stack storage
   // ----------------------------------------------------------------
   always_comb begin
      top_we = 1'b0;
      top_waddr = ptr_reg;
      top_wdata = top_rd;
      if (do_push && !push_full) begin
         top_we = 1'b1;
         top_waddr = ptr_reg + 5'h01;
         top_wdata = i_pc;
      end else if (i_wr && !is_reset) begin
         unique case (i_addr)
            rstack_pkg::ADDR_TOP_LOW: begin
               top_we = 1'b1;
               top_wdata = put_byte(top_rd, 2'h0, i_wdata);
            end
            rstack_pkg::ADDR_TOP_HIGH: begin
               top_we = 1'b1;
               top_wdata = put_byte(top_rd, 2'h1, i_wdata);
            end
            rstack_pkg::ADDR_TOP_UPPER: begin
               top_we = 1'b1;
               top_wdata = put_byte(top_rd, 2'h2, i_wdata);
            end
            default: begin
               top_we = 1'b0;
            end
         endcase
      end
   end

   stack_ram u_ram (
      .i_mclk(i_mclk),
      .i_we(top_we),
      .i_waddr(top_waddr),
      .i_wdata(top_wdata),
      .i_raddr(ptr_reg),
      .o_rdata(top_rd)
   );

   // ----------------------------------------------------------------
   // stack pointer and fault flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ptr_reg <= rstack_pkg::PTR_ZERO;
      end else if (is_reset) begin
         ptr_reg <= rstack_pkg::PTR_ZERO;
      end else if (do_push && !push_full) begin
         ptr_reg <= ptr_reg + 5'h01;
      end else if (do_pop && !pop_empty) begin
         ptr_reg <= ptr_reg - 5'h01;
      end else if (wr_sp) begin
         ptr_reg <= i_wdata[rstack_pkg::PTR_W-1:0];
      end
   end

   // set wins over a software clear in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         full_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else if (is_por) begin
         full_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         if (push_full || (do_push && ptr_reg == rstack_pkg::PTR_LAST - 5'h01)) begin
            full_reg <= 1'b1;
         end else if (wr_sp && !i_wdata[rstack_pkg::SP_FULL_BIT]) begin
            full_reg <= 1'b0;
         end
         if (pop_empty) begin
            unf_reg <= 1'b1;
         end else if (wr_sp && !i_wdata[rstack_pkg::SP_UNF_BIT]) begin
            unf_reg <= 1'b0;
         end
      end
   end

   assign fault_hit = push_full || (do_push && ptr_reg == rstack_pkg::PTR_LAST - 5'h01) || pop_empty;

   // flag is set in the fault cycle, reset pulse follows one cycle later
   always_comb begin
      fault_next = fault_reg;
      unique case (fault_reg)
         rstack_pkg::ST_RUN: begin
            if (fault_hit && i_stack_fault_reset_enable) begin
               fault_next = rstack_pkg::ST_FAULT;
            end
         end
         rstack_pkg::ST_FAULT: begin
            fault_next = rstack_pkg::ST_HOLD;
         end
         rstack_pkg::ST_HOLD: begin
            fault_next = rstack_pkg::ST_RUN;
         end
         default: begin
            fault_next = rstack_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fault_reg <= rstack_pkg::ST_RUN;
         o_device_reset <= 1'b0;
      end else begin
         fault_reg <= fault_next;
         o_device_reset <= (fault_reg == rstack_pkg::ST_FAULT);
      end
   end

   // ----------------------------------------------------------------
   // fast context shadow
   // ----------------------------------------------------------------
   // no reset: keeps value through every reset
   always_ff @(posedge i_mclk) begin
      if (i_op.irq_vector || i_op.call_fast) begin
         shadow_reg <= i_ctx;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ctx_restore <= '0;
         o_ctx_restore_valid <= 1'b0;
      end else begin
         o_ctx_restore <= shadow_reg;
         o_ctx_restore_valid <= (i_op.return_from_interrupt_fast || i_op.ret_fast) && !is_reset;
      end
   end

   // ----------------------------------------------------------------
   // program counter load on reset and wake-up
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pc_load <= rstack_pkg::PC_RESET;
         o_pc_load_valid <= 1'b0;
      end else begin
         o_pc_load_valid <= (i_event != rstack_pkg::EV_NONE) || do_pop;
         if (is_reset) begin
            o_pc_load <= rstack_pkg::PC_RESET;
         end else if (i_event == rstack_pkg::EV_IRQ_WAKE
            && (i_high_irq_global_enable || i_low_irq_global_enable)) begin
            o_pc_load <= i_irq_high_pending ? rstack_pkg::VEC_HIGH : rstack_pkg::VEC_LOW;
         end else if (i_event == rstack_pkg::EV_WDT_WAKE || i_event == rstack_pkg::EV_IRQ_WAKE) begin
            o_pc_load <= i_pc + rstack_pkg::PC_STEP;
         end else begin
            o_pc_load <= top_rd;
         end
      end
   end

   // ----------------------------------------------------------------
   // reset control / status flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         interrupt_priority_enable_reg <= 1'b0;
         ri_reg <= 1'b1;
         to_reg <= 1'b1;
         pd_reg <= 1'b1;
         por_reg <= 1'b0;
         bor_reg <= 1'b0;
      end else begin
         if (i_wr && i_addr == rstack_pkg::ADDR_RESET_CONTROL_STATUS) begin
            interrupt_priority_enable_reg <= i_wdata[rstack_pkg::RC_INTERRUPT_PRIORITY_ENABLE_BIT];
            ri_reg <= i_wdata[rstack_pkg::RC_RI_BIT];
            por_reg <= i_wdata[rstack_pkg::RC_POR_BIT];
            bor_reg <= i_wdata[rstack_pkg::RC_BOR_BIT];
         end
         unique case (i_event)
            rstack_pkg::EV_POR: begin
               interrupt_priority_enable_reg <= 1'b0;
               ri_reg <= 1'b1;
               to_reg <= 1'b1;
               pd_reg <= 1'b1;
               por_reg <= 1'b0;
               bor_reg <= 1'b0;
            end
            rstack_pkg::EV_RESET_INSTR: ri_reg <= 1'b0;
            rstack_pkg::EV_BROWNOUT: begin
               ri_reg <= 1'b1;
               to_reg <= 1'b1;
               pd_reg <= 1'b1;
               bor_reg <= 1'b0;
            end
            rstack_pkg::EV_EXTERNAL_MASTER_CLEAR_RUN: to_reg <= 1'b1;
            rstack_pkg::EV_EXTERNAL_MASTER_CLEAR_SLEEP: begin
               to_reg <= 1'b1;
               pd_reg <= 1'b0;
            end
            rstack_pkg::EV_WDT_RUN: to_reg <= 1'b0;
            rstack_pkg::EV_WDT_WAKE: begin
               to_reg <= 1'b0;
               pd_reg <= 1'b0;
            end
            rstack_pkg::EV_IRQ_WAKE: pd_reg <= 1'b0;
            default: begin
            end
         endcase
      end
   end

   // software brownout enable: set from config by power-on events (0 on i_rst_n), kept by other resets only in BOR_SOFT_MODE
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         software_brownout_enable_reg <= 1'b0;
      end else if (is_por
         || (is_reset && i_brownout_mode_config != rstack_pkg::BOR_SOFT_MODE)) begin
         software_brownout_enable_reg <= (i_brownout_mode_config == rstack_pkg::BOR_SOFT_MODE);
      end else if (i_wr && i_addr == rstack_pkg::ADDR_RESET_CONTROL_STATUS) begin
         software_brownout_enable_reg <= i_wdata[rstack_pkg::RC_SBOR_BIT];
      end
   end

   // ----------------------------------------------------------------
   // read port and top of stack output
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= rstack_pkg::BYTE_ZERO;
         o_top_of_stack <= rstack_pkg::PC_RESET;
      end else begin
         o_top_of_stack <= top_rd;
         o_rdata <= rstack_pkg::BYTE_ZERO;
         if (i_rd) begin
            unique case (i_addr)
               rstack_pkg::ADDR_RETURN_STACK_POINTER: o_rdata <= {full_reg, unf_reg, 1'b0, ptr_reg};
               rstack_pkg::ADDR_TOP_LOW: o_rdata <= get_byte(top_rd, 2'h0);
               rstack_pkg::ADDR_TOP_HIGH: o_rdata <= get_byte(top_rd, 2'h1);
               rstack_pkg::ADDR_TOP_UPPER: o_rdata <= get_byte(top_rd, 2'h2);
               rstack_pkg::ADDR_RESET_CONTROL_STATUS: o_rdata <= {interrupt_priority_enable_reg, software_brownout_enable_reg, 1'b0, ri_reg, to_reg, pd_reg,
                  por_reg, bor_reg};
               default: o_rdata <= rstack_pkg::BYTE_ZERO;
            endcase
         end
      end
   end
endmodule

// ### sim/core_seq_model.sv
// partner model: core sequencer issuing stack ops, context and reset events
// assumes: called by testbench tasks; follows every pc redirect from the block
`timescale 1ns/100ps
module core_seq_model (
   input wire logic i_mclk,
   input wire logic [rstack_pkg::PC_W-1:0] i_pc_load,
   input wire logic i_pc_load_valid,
   output rstack_pkg::stack_op_t o_op,
   output logic [rstack_pkg::PC_W-1:0] o_pc,
   output rstack_pkg::core_ctx_t o_ctx,
   output rstack_pkg::reset_event_t o_event
);
   // ------
   // sequencer
   // ------
   initial begin
      o_op = '0;
      o_pc = '0;
      o_ctx = '0;
      o_event = rstack_pkg::EV_NONE;
   end
   always @(posedge i_mclk) begin
      if (i_pc_load_valid === 1'b1) o_pc <= i_pc_load;
   end
   // two idle edges first so a pending pc load lands before the new pc is set
   task automatic issue(input logic [5:0] op, input rstack_pkg::reset_event_t ev,
                        input logic [rstack_pkg::PC_W-1:0] pc, input logic [23:0] ctx);
      repeat (2) @(posedge i_mclk);
      o_op <= op;
      o_event <= ev;
      o_pc <= pc;
      o_ctx <= ctx;
      @(posedge i_mclk);
      o_op <= '0;
      o_event <= rstack_pkg::EV_NONE;
   endtask
endmodule

// ### sim/rstack_assertions.sv
// checker: port timing of the return stack and reset-cause block
// assumes: bound to return_stack_reset_flags, single clock domain
`timescale 1ns/100ps
module rstack_assertions (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic i_rd,
   input wire rstack_pkg::stack_op_t i_op,
   input wire logic [rstack_pkg::PC_W-1:0] i_pc,
   input wire rstack_pkg::core_ctx_t i_ctx,
   input wire rstack_pkg::reset_event_t i_event,
   input wire logic i_stack_fault_reset_enable,
   input wire logic i_high_irq_global_enable,
   input wire logic i_low_irq_global_enable,
   input wire logic i_irq_high_pending,
   input wire logic [7:0] o_rdata,
   input wire logic [rstack_pkg::PC_W-1:0] o_pc_load,
   input wire logic o_pc_load_valid,
   input wire rstack_pkg::core_ctx_t o_ctx_restore,
   input wire logic o_ctx_restore_valid,
   input wire logic o_device_reset
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   rstack_pkg::core_ctx_t shadow_q;
   logic ret_any;
   logic irq_en;
   assign ret_any = i_op.ret_fast | i_op.return_from_interrupt_fast;
   assign irq_en = i_high_irq_global_enable | i_low_irq_global_enable;
   // ------
   // reference shadow and assertions
   // ------
   always_ff @(posedge i_mclk) begin
      if (i_op.irq_vector | i_op.call_fast) shadow_q <= i_ctx;
   end
   a_rd_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_ptr_bit5_zero: assert property ($past(i_rd) && $past(i_addr) == rstack_pkg::ADDR_RETURN_STACK_POINTER |-> !o_rdata[5])
      else $error("pointer bit 5 reads one");
   a_restore_shadow_value: assert property (ret_any |=> o_ctx_restore_valid && o_ctx_restore == shadow_q)
      else $error("fast return context wrong");
   a_restore_has_cause: assert property (o_ctx_restore_valid |-> $past(ret_any))
      else $error("context restore without fast return");
   a_fault_rst_enabled: assert property (o_device_reset |-> $past(i_stack_fault_reset_enable, 2))
      else $error("fault reset while disabled");
   a_fault_rst_pulse: assert property (o_device_reset |=> !o_device_reset)
      else $error("fault reset longer than one cycle");
   a_pc_reset_zero: assert property ($past(i_event) inside {[rstack_pkg::EV_POR:rstack_pkg::EV_EXTERNAL_MASTER_CLEAR_FULL]}
      |-> o_pc_load_valid && o_pc_load == rstack_pkg::PC_RESET) else $error("reset pc not zero");
   a_pc_wake_step: assert property ($past(i_event) == rstack_pkg::EV_WDT_WAKE ||
      $past(i_event) == rstack_pkg::EV_IRQ_WAKE && !$past(irq_en)
      |-> o_pc_load_valid && o_pc_load == $past(i_pc) + rstack_pkg::PC_STEP) else $error("wake pc not pc+2");
   a_pc_irq_vector: assert property ($past(i_event) == rstack_pkg::EV_IRQ_WAKE && $past(irq_en)
      |-> o_pc_load == ($past(i_irq_high_pending) ? rstack_pkg::VEC_HIGH : rstack_pkg::VEC_LOW))
      else $error("wake vector wrong");
   a_pop_pc_load: assert property ((i_op.pop | ret_any) |=> o_pc_load_valid)
      else $error("pop without pc load");
   c_fault_reset: cover property (o_device_reset);
   c_ctx_restore: cover property (o_ctx_restore_valid);
   c_irq_wake: cover property ($past(i_event) == rstack_pkg::EV_IRQ_WAKE && $past(irq_en));
endmodule
bind return_stack_reset_flags rstack_assertions u_chk (.i_mclk, .i_rst_n, .i_addr, .i_rd, .i_op, .i_pc, .i_ctx,
   .i_event, .i_stack_fault_reset_enable, .i_high_irq_global_enable, .i_low_irq_global_enable,
   .i_irq_high_pending, .o_rdata, .o_pc_load, .o_pc_load_valid, .o_ctx_restore, .o_ctx_restore_valid,
   .o_device_reset);

// ### sim/testbench.sv
// testbench: registers, stack ops, shadow and reset events with self checks
// assumes: core_seq_model drives op, pc, context and event inputs
`timescale 1ns/100ps
module testbench;
   localparam logic [5:0] PUSH = 6'h20, POP = 6'h10, CALLF = 6'h08, RETF = 6'h04, IRQV = 6'h02, RETURN_FROM_INTERRUPT = 6'h01;
   logic i_mclk, i_rst_n, i_wr, i_rd, fault_en, hi_en, lo_en, hi_pend, o_pc_load_valid, o_ctx_restore_valid;
   logic o_device_reset;
   logic [2:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rd;
   logic [1:0] bor_cfg;
   logic [20:0] o_pc_load, pc, top_of_stack;
   rstack_pkg::stack_op_t op;
   rstack_pkg::core_ctx_t ctx, o_ctx_restore, last_ctx;
   rstack_pkg::reset_event_t ev;
   int n_fail = 0, tests_run = 0, n_dev_rst = 0;
   core_seq_model i_core_seq_model (.i_mclk, .i_pc_load(o_pc_load), .i_pc_load_valid(o_pc_load_valid),
      .o_op(op), .o_pc(pc), .o_ctx(ctx), .o_event(ev));
   return_stack_reset_flags i_return_stack_reset_flags (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .i_op(op), .i_pc(pc), .i_ctx(ctx), .i_event(ev), .i_stack_fault_reset_enable(fault_en),
      .i_brownout_mode_config(bor_cfg), .i_high_irq_global_enable(hi_en), .i_low_irq_global_enable(lo_en),
      .i_irq_high_pending(hi_pend), .o_top_of_stack(top_of_stack), .o_pc_load, .o_pc_load_valid, .o_ctx_restore,
      .o_ctx_restore_valid, .o_device_reset);
   // ------
   // clock, monitors, bus tasks
   // ------
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      if (o_device_reset === 1'b1) n_dev_rst++;
      if (o_ctx_restore_valid === 1'b1) last_ctx <= o_ctx_restore;
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 chk(what, o_rdata, exp);
   endtask
   task automatic do_op(input logic [5:0] k, input logic [20:0] p = '0, input logic [23:0] c = '0);
      i_core_seq_model.issue(k, rstack_pkg::EV_NONE, p, c);
   endtask
   task automatic ev_go(input rstack_pkg::reset_event_t e, input logic [20:0] p);
      i_core_seq_model.issue(6'h00, e, p, 24'h000000);
   endtask
   task automatic pc_chk(input string what, input logic [20:0] exp);
      @(posedge i_mclk);
      #1 chk(what, pc, exp);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_push_pop();
      do_op(PUSH, 21'h1a2b3c);
      do_op(PUSH, 21'h0f5e6d);
      rd_chk("ptr two", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h02);
      rd_chk("top low", rstack_pkg::ADDR_TOP_LOW, 8'h6d);
      rd_chk("top high", rstack_pkg::ADDR_TOP_HIGH, 8'h5e);
      rd_chk("top upper", rstack_pkg::ADDR_TOP_UPPER, 8'h0f);
      reg_wr(rstack_pkg::ADDR_TOP_LOW, 8'h11);
      reg_wr(rstack_pkg::ADDR_TOP_HIGH, 8'h22);
      reg_wr(rstack_pkg::ADDR_TOP_UPPER, 8'hf3);
      rd_chk("top upper written", rstack_pkg::ADDR_TOP_UPPER, 8'h13);
      chk("top of stack out", top_of_stack, 21'h132211);
      do_op(PUSH, 21'h000444);
      do_op(POP);
      pc_chk("pop returns top", 21'h000444);
      do_op(POP);
      pc_chk("pop to written top", 21'h132211);
      rd_chk("ptr one", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h01);
      rd_chk("top after pop", rstack_pkg::ADDR_TOP_LOW, 8'h3c);
      do_op(POP);
   endtask
   task automatic t_shadow();
      do_op(IRQV, 21'h000010, 24'h0a0b0c);
      do_op(IRQV, 21'h000020, 24'h1a1b1c);
      do_op(RETURN_FROM_INTERRUPT);
      pc_chk("return_from_interrupt pc", 21'h000020);
      chk("return_from_interrupt restore", last_ctx, 24'h1a1b1c);
      do_op(CALLF, 21'h000030, 24'h2a2b2c);
      do_op(RETF);
      @(posedge i_mclk);
      #1 chk("fast return restore", last_ctx, 24'h2a2b2c);
      do_op(POP);
   endtask
   task automatic t_full();
      fault_en <= 1'b1;
      n_dev_rst = 0;
      for (int i = 1; i < 32; i++) do_op(PUSH, 21'(i));
      rd_chk("full at last", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h9f);
      do_op(PUSH, 21'h000077);
      rd_chk("overflow ptr", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h9f);
      rd_chk("overflow discarded", rstack_pkg::ADDR_TOP_LOW, 8'h1f);
      chk("fault reset", n_dev_rst > 0, 24'h1);
      reg_wr(rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'hdf);
      rd_chk("flags not set by write", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h9f);
      reg_wr(rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h00);
      rd_chk("flags cleared", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h00);
   endtask
   task automatic t_underflow();
      fault_en <= 1'b0;
      n_dev_rst = 0;
      do_op(POP);
      repeat (3) @(posedge i_mclk);
      rd_chk("underflow", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h40);
      chk("no fault reset", n_dev_rst, 24'h0);
   endtask
   task automatic t_events();
      logic [7:0] exp_rc [2:8] = '{8'h4c, 8'h5c, 8'h5c, 8'h58, 8'h54, 8'h5c, 8'h50};
      bor_cfg <= 2'h0;
      ev_go(rstack_pkg::EV_POR, 21'h000100);
      rd_chk("power on cfg0", rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h1c);
      rd_chk("power on clears flags", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h00);
      bor_cfg <= 2'h1;
      for (int i = 2; i < 9; i++) begin
         ev_go(rstack_pkg::EV_POR, 21'h000100);
         rd_chk("power on cfg1", rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h5c);
         ev_go(rstack_pkg::reset_event_t'(i), 21'h000100);
         pc_chk("event pc", (i == 8) ? 21'h000102 : 21'h000000);
         rd_chk("event flags", rstack_pkg::ADDR_RESET_CONTROL_STATUS, exp_rc[i]);
      end
      for (int j = 0; j < 3; j++) begin
         hi_en <= (j == 1);
         lo_en <= (j == 2);
         hi_pend <= (j == 1);
         ev_go(rstack_pkg::EV_POR, 21'h000100);
         ev_go(rstack_pkg::EV_IRQ_WAKE, 21'h000200);
         pc_chk("wake pc", (j == 0) ? 21'h000202 : (j == 1) ? rstack_pkg::VEC_HIGH : rstack_pkg::VEC_LOW);
         rd_chk("wake flags", rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h58);
      end
      reg_wr(rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h80);
      rd_chk("software reset_control_status write", rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h88);
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      i_rst_n = 1'b0;
      {i_addr, i_wdata, i_wr, i_rd, fault_en, hi_en, lo_en, hi_pend} = '0;
      bor_cfg = 2'h1;
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rd_chk("ptr after reset", rstack_pkg::ADDR_RETURN_STACK_POINTER, 8'h00);
      rd_chk("flags after reset", rstack_pkg::ADDR_RESET_CONTROL_STATUS, 8'h1c);
      rd_chk("unmapped read", 3'h7, 8'h00);
      t_push_pop();
      t_shadow();
      t_full();
      t_underflow();
      t_events();
      wrap_up();
   end
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
endmodule
